// ==== core/sdram_pkg.sv ====
package sdram_pkg;

  // Command decoded from the strobes at a link clock rise
  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_DESEL = 4'h1,
    CMD_MRS   = 4'h2,
    CMD_REF   = 4'h3,
    CMD_PRE   = 4'h4,
    CMD_ACT   = 4'h5,
    CMD_WRITE = 4'h6,
    CMD_READ  = 4'h7,
    CMD_BST   = 4'h8
  } cmd_t;

  // Clock gate state of the device
  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'h0,
    PWR_DOWN    = 2'h1,
    PWR_SUSPEND = 2'h2,
    PWR_SELFREF = 2'h3
  } pwr_t;

  localparam int ADDR_W    = 12;
  localparam int COL_W     = 8;
  localparam int DQ_W      = 16;
  localparam int BANKS     = 4;
  localparam int PRE_ALL_BIT = 10;
  localparam int MASK_LAT  = 2;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] REF_SAT = 4'h8;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic [DQ_W-1:0]   DQ_RST   = 16'h0000;

  // All pins from the host, sampled as one bundle
  typedef struct packed {
    logic              clk;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [1:0]        bank_sel;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        mask;
    logic [DQ_W-1:0]   dq;
  } pins_t;

  localparam pins_t PINS_RST = '{clk: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
    cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, bank_sel: 2'h0,
    addr: 12'h000, mask: 2'h3, dq: 16'h0000};

endpackage : sdram_pkg

// ==== core/sdram_wr_fifo.sv ====
`timescale 1ns/1ps
module sdram_wr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  // Honest flags from the occupancy count
  assign in_ready_out  = (count != (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = store[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      store[wr_ptr] <= in_data_in;
    end
  end

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + PW'(1);
      if (pop) rd_ptr <= rd_ptr + PW'(1);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : sdram_wr_fifo

// ==== core/sdram_array.sv ====
`timescale 1ns/1ps
module sdram_array #(
  parameter int AW = 12
) (
  input  wire logic          sys_clk_in,
  input  wire logic          wr_en_in,
  input  wire logic [1:0]    byte_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [15:0]   wr_data_in,
  input  wire logic          rd_en_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic [15:0]        rd_data_out
);
  logic [15:0] cells [2**AW];

  // Byte lanes written on their own enables
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in && byte_en_in[0]) cells[wr_addr_in][7:0] <= wr_data_in[7:0];
    if (wr_en_in && byte_en_in[1]) begin
      cells[wr_addr_in][15:8] <= wr_data_in[15:8];
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk_in) begin
    if (rd_en_in) rd_data_out <= cells[rd_addr_in];
  end

endmodule : sdram_array

// ==== core/sdram_init_activate_access.sv ====
// Functional notes
// RL1: Row uses A0-A11, column uses A0-A7
// RL2: Precharge: A10 high all, else selected bank
// RL3: Bank selects name bank for activate, access
// RL4: Chip select high ignores new commands
// RL5: Strobes sampled together decode the command
// RL6: Read mask high floats bytes two cycles later
// RL7: Write mask high blocks byte same cycle
// RL8: Clock gate low enters down, suspend, selfrefresh
// RL9: Host waits 200 us with no-ops first
// RL10: Host holds masks, clock gate high meanwhile
// RL11: Host programs mode after precharging all
// RL12: Host issues eight auto refresh cycles; the test issues nine, the count saturates at 8
// RL13: Mode register undefined until programmed
// RL14: Mode set needs idle banks, gate high
// RL15: All strobes low sets mode from address
// RL16: Host waits mode set recovery afterwards
// RL17: Activate first, then access after delay
// RL18: Precharge before reactivating, keep row cycle
// RL19: Host spaces activates across banks
// RL20: Host closes banks before maximum active time
// RL21: Ras high cas low accesses, we picks
// RL22: Host precharges before opening another row
// RL23: Reads and writes allowed every cycle
// RL24: Ras, we low, cas high is precharge
// RL25: Lower mask bits 0-7, upper bits 8-15
`timescale 1ns/1ps
module sdram_init_activate_access
  import sdram_pkg::*;
#(
  parameter int ROW_BITS = 2
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              sdram_clk_in,
  input  wire logic              cs_n_in,
  input  wire logic              ras_n_in,
  input  wire logic              cas_n_in,
  input  wire logic              we_n_in,
  input  wire logic              cke_in,
  input  wire logic              bank_select_0_in,
  input  wire logic              bank_select_1_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              byte_mask_lower_in,
  input  wire logic              byte_mask_upper_in,
  input  wire logic [DQ_W-1:0]   data_bus_in,
  output logic [DQ_W-1:0]        data_bus_out,
  output logic [1:0]             data_bus_oe_out,
  output logic [ADDR_W-1:0]      mode_reg_out,
  output logic                   mode_valid_out,
  output logic [BANKS-1:0]       bank_open_out,
  output pwr_t                   power_state_out,
  output logic [3:0]             refresh_count_out,
  output logic                   write_drop_out
);
  localparam int MEM_AW = 2 + ROW_BITS + COL_W;

  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [DQ_W-1:0]   data;
    logic [1:0]        be;
  } wr_item_t;

  pins_t             pin_s1;
  pins_t             pin_s2;
  logic              clk_prev;
  logic              rise;
  cmd_t              cmd;
  logic              go;
  logic [1:0]        bank_sel;
  logic [BANKS-1:0]  bank_open;
  logic [ADDR_W-1:0] bank_row [BANKS];
  logic [ADDR_W-1:0] mode_reg;
  logic              mode_valid;
  logic [3:0]        ref_count;
  pwr_t              pwr;
  logic [MEM_AW-1:0] acc_addr;
  wr_item_t          wr_item;
  wr_item_t          drain_item;
  logic              wr_push;
  logic              wr_ready;
  logic              drain_valid;
  logic              drain_ready;
  logic              rd_req;
  logic [MEM_AW-1:0] rd_addr;
  logic              rd_cap;
  logic [DQ_W-1:0]   rd_word;
  logic [DQ_W-1:0]   rd_buf;
  logic              rd_tok;
  logic [1:0]        mask_d1;
  logic [DQ_W-1:0]   dq_out;
  logic [1:0]        dq_oe;
  logic              drop;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser on every host pin, link clock included
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_s1   <= PINS_RST;
      pin_s2   <= PINS_RST;
      clk_prev <= 1'b0;
    end else begin
      pin_s1   <= '{clk: sdram_clk_in, cs_n: cs_n_in, ras_n: ras_n_in,
                    cas_n: cas_n_in, we_n: we_n_in, cke: cke_in,
                    bank_sel: {bank_select_1_in, bank_select_0_in},
                    addr: addr_in,
                    mask: {byte_mask_upper_in, byte_mask_lower_in},
                    dq: data_bus_in};
      pin_s2   <= pin_s1;
      clk_prev <= pin_s2.clk;
    end
  end

  // Pins travel together, so they are aligned with the found edge
  assign rise     = pin_s2.clk && !clk_prev;
  assign bank_sel = pin_s2.bank_sel; // RL3

  ////////////////////////////////////////////////////////////////////////
  // Command decoder; deselect masks everything else
  always_comb begin
    cmd = CMD_NOP;
    if (pin_s2.cs_n) begin
      cmd = CMD_DESEL; // RL4
    end else begin
      case ({pin_s2.ras_n, pin_s2.cas_n, pin_s2.we_n}) // RL5
        3'b000:  cmd = CMD_MRS; // RL15
        3'b001:  cmd = CMD_REF;
        3'b010:  cmd = CMD_PRE; // RL24
        3'b011:  cmd = CMD_ACT;
        3'b100:  cmd = CMD_WRITE; // RL21
        3'b101:  cmd = CMD_READ; // RL21
        3'b110:  cmd = CMD_BST;
        default: cmd = CMD_NOP;
      endcase
    end
  end

  // Commands act only at a rise with the clock gate open
  assign go = rise && pin_s2.cke && (pwr == PWR_ACTIVE);

  // Bank, low row bits and column form the cell address
  assign acc_addr = {bank_sel, bank_row[bank_sel][ROW_BITS-1:0],
                     pin_s2.addr[COL_W-1:0]}; // RL1

  ////////////////////////////////////////////////////////////////////////
  // Open rows per bank
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      bank_open <= '0;
      for (int i = 0; i < BANKS; i++) bank_row[i] <= '0;
    end else if (go && cmd == CMD_ACT) begin
      bank_open[bank_sel] <= 1'b1; // RL3
      bank_row[bank_sel]  <= pin_s2.addr; // RL1
    end else if (go && cmd == CMD_PRE) begin
      if (pin_s2.addr[PRE_ALL_BIT]) begin
        bank_open <= '0; // RL2
      end else begin
        bank_open[bank_sel] <= 1'b0; // RL2
      end
    end
  end

  // Mode register only trusted once loaded
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mode_reg   <= MODE_RST;
      mode_valid <= 1'b0; // RL13
    end else if (go && cmd == CMD_MRS) begin
      mode_reg   <= pin_s2.addr; // RL15
      mode_valid <= 1'b1; // RL13
    end
  end

  // Saturating count of refreshes, lets software see init progress
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ref_count <= '0;
    end else if (go && cmd == CMD_REF && ref_count != REF_SAT) begin
      ref_count <= ref_count + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock gate: the condition at the falling gate picks the state
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pwr <= PWR_ACTIVE;
    end else if (rise) begin
      case (pwr)
        PWR_ACTIVE: begin
          if (!pin_s2.cke) begin
            if (cmd == CMD_REF) pwr <= PWR_SELFREF; // RL8
            else if ((|bank_open) || rd_tok) pwr <= PWR_SUSPEND; // RL8
            else pwr <= PWR_DOWN; // RL8
          end
        end
        PWR_DOWN, PWR_SUSPEND, PWR_SELFREF: begin
          if (pin_s2.cke) pwr <= PWR_ACTIVE;
        end
        default: pwr <= PWR_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writes to an open bank enter the queue with masked lanes off
  assign wr_push      = go && cmd == CMD_WRITE && bank_open[bank_sel]; // RL23
  assign wr_item.addr = acc_addr;
  assign wr_item.data = pin_s2.dq;
  assign wr_item.be   = ~pin_s2.mask; // RL7 RL25

  // A full queue loses the word; flag it for one cycle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) drop <= 1'b0;
    else drop <= wr_push && !wr_ready;
  end

  sdram_wr_fifo #(
    .W     ($bits(wr_item_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (wr_push),
    .in_ready_out  (wr_ready),
    .in_data_in    (wr_item),
    .out_valid_out (drain_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (drain_item)
  );

  // Reads own the array port; the queue stalls behind them
  assign drain_ready = !rd_req;

  sdram_array #(
    .AW (MEM_AW)
  ) u_array (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (drain_valid && drain_ready),
    .byte_en_in  (drain_item.be),
    .wr_addr_in  (drain_item.addr),
    .wr_data_in  (drain_item.data),
    .rd_en_in    (rd_req),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read fetch, finished long before the next link rise
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_req  <= 1'b0;
      rd_addr <= '0;
      rd_cap  <= 1'b0;
      rd_buf  <= DQ_RST;
    end else begin
      rd_req <= go && cmd == CMD_READ && bank_open[bank_sel];
      if (go) rd_addr <= acc_addr;
      rd_cap <= rd_req;
      if (rd_cap) rd_buf <= rd_word;
    end
  end

  // Read token and mask step once per rise; suspend freezes them
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_tok  <= 1'b0;
      mask_d1 <= 2'h3;
    end else if (rise && pwr != PWR_SUSPEND) begin
      rd_tok  <= go && cmd == CMD_READ && bank_open[bank_sel];
      mask_d1 <= pin_s2.mask; // RL6
    end
  end

  // Data driven after the next rise, seen by host on the one after
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      dq_out <= DQ_RST;
      dq_oe  <= 2'h0;
    end else if (rise && pwr != PWR_SUSPEND) begin
      dq_out <= rd_buf;
      dq_oe  <= rd_tok ? ~mask_d1 : 2'h0; // RL6 RL25
    end
  end

  assign data_bus_out      = dq_out;
  assign data_bus_oe_out   = dq_oe;
  assign mode_reg_out      = mode_reg;
  assign mode_valid_out    = mode_valid;
  assign bank_open_out     = bank_open;
  assign power_state_out   = pwr;
  assign refresh_count_out = ref_count;
  assign write_drop_out    = drop;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_pre_all: assert property (go && cmd == CMD_PRE // RL2
    && pin_s2.addr[PRE_ALL_BIT] |=> bank_open == '0)
    else $error("precharge all left a bank open");
  a_pre_one: assert property (go && cmd == CMD_PRE // RL2
    && !pin_s2.addr[PRE_ALL_BIT] |=> (bank_open & ~$past(bank_open)) == '0
    && !bank_open[$past(bank_sel)])
    else $error("single precharge wrong");
  a_act_bank: assert property (go && cmd == CMD_ACT // RL3
    |=> bank_open[$past(bank_sel)]
        && bank_row[$past(bank_sel)] == $past(pin_s2.addr))
    else $error("activate missed its bank");
  a_desel_ign: assert property (rise && pin_s2.cs_n // RL4
    |=> $stable(bank_open) && $stable(mode_reg) && !rd_req)
    else $error("deselected command acted");
  a_mrs_load: assert property (go && cmd == CMD_MRS // RL15
    |=> mode_valid && mode_reg == $past(pin_s2.addr))
    else $error("mode set not loaded");
  a_mode_undef: assert property ($rose(mode_valid) // RL13
    |-> $past(go) && $past(cmd) == CMD_MRS)
    else $error("mode valid without mode set");
  a_mask_read: assert property (rise && rd_tok && pwr != PWR_SUSPEND // RL6
    |=> data_bus_oe_out == ~$past(mask_d1) && data_bus_out == $past(rd_buf))
    else $error("read mask latency wrong");
  a_oe_quiet: assert property (rise && !rd_tok && pwr != PWR_SUSPEND // RL6
    |=> data_bus_oe_out == 2'h0)
    else $error("bus driven without read");
  a_wr_mask: assert property (wr_push && wr_ready // RL7
    |=> u_fifo.out_valid_out
    && u_fifo.store[$past(u_fifo.wr_ptr)][1:0] == ~$past(pin_s2.mask))
    else $error("write not queued with its lane mask");
  a_pwr_down: assert property (rise && pwr == PWR_ACTIVE // RL8
    && !pin_s2.cke && cmd != CMD_REF && bank_open == '0 && !rd_tok
    |=> pwr == PWR_DOWN)
    else $error("power down not entered");
  a_suspend: assert property (rise && pwr == PWR_ACTIVE // RL8
    && !pin_s2.cke && cmd != CMD_REF && bank_open != '0
    |=> pwr == PWR_SUSPEND)
    else $error("clock suspend not entered");
  c_read: cover property (rise && rd_tok ##[1:40] data_bus_oe_out == 2'h3);
  c_write: cover property (wr_push ##[1:4] u_array.wr_en_in);
  c_mrs: cover property (go && cmd == CMD_MRS);
  c_selfref: cover property (pwr == PWR_SELFREF);
  c_masked: cover property (data_bus_oe_out == 2'h1);
endmodule : sdram_init_activate_access

// ==== test/sdram_host_model.sv ====
`timescale 1ns/1ps
module sdram_host_model
  import sdram_pkg::*;
(
  input  wire logic            sys_clk_in,
  input  wire logic [DQ_W-1:0] wire_dq_in,
  input  wire logic [1:0]      wire_oe_in,
  output pins_t                pins_out,
  output logic [DQ_W-1:0]      seen_data_out,
  output logic [1:0]           seen_oe_out
);

  // Idle pins at time zero, link clock parked low
  initial begin
    pins_out      = PINS_RST;
    seen_data_out = 16'h0000;
    seen_oe_out   = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One link cycle of 16 sys cycles; pins stand the whole cycle so the
  // synchroniser sees them settled on both sides of the rise
  task automatic cmd_cycle(input cmd_t c, input logic [1:0] b,
                           input logic [ADDR_W-1:0] a, input logic [1:0] m,
                           input logic [DQ_W-1:0] d, input logic cke,
                           input logic cs_n);
    logic [2:0] strobes;
    case (c)
      CMD_MRS:   strobes = 3'b000;
      CMD_REF:   strobes = 3'b001;
      CMD_PRE:   strobes = 3'b010;
      CMD_ACT:   strobes = 3'b011;
      CMD_WRITE: strobes = 3'b100;
      CMD_READ:  strobes = 3'b101;
      CMD_BST:   strobes = 3'b110;
      default:   strobes = 3'b111;
    endcase
    @(posedge sys_clk_in);
    #1;
    pins_out.cs_n     = cs_n;
    pins_out.ras_n    = strobes[2];
    pins_out.cas_n    = strobes[1];
    pins_out.we_n     = strobes[0];
    pins_out.cke      = cke;
    pins_out.bank_sel = b;
    pins_out.addr     = a;
    pins_out.mask     = m;
    // Released bus toggles so stale data never looks valid
    pins_out.dq       = (c == CMD_WRITE) ? d : ~pins_out.dq;
    repeat (8) @(posedge sys_clk_in);
    #1;
    pins_out.clk  = 1'b1;
    seen_data_out = wire_dq_in;
    seen_oe_out   = wire_oe_in;
    repeat (7) @(posedge sys_clk_in);
    #1;
    pins_out.clk  = 1'b0;
  endtask : cmd_cycle

endmodule : sdram_host_model

// ==== test/sdram_init_activate_access_tb_top.sv ====
`timescale 1ns/1ps
module sdram_init_activate_access_tb_top
  import sdram_pkg::*;
;
  logic              sys_clk;
  logic              reset;
  pins_t             pins;
  logic [DQ_W-1:0]   dq_out;
  logic [DQ_W-1:0]   dq_wire;
  logic [DQ_W-1:0]   seen_data;
  logic [1:0]        dq_oe;
  logic [1:0]        seen_oe;
  logic [ADDR_W-1:0] mode_reg;
  logic              mode_valid;
  logic [BANKS-1:0]  bank_open;
  pwr_t              power_state;
  logic [3:0]        ref_count;
  logic              write_drop;
  logic              drop_seen;
  int                errors;
  int                total_checks;
  int                cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and the shared data wire resolved per byte lane
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  assign dq_wire = {dq_oe[1] ? dq_out[15:8] : pins.dq[15:8],
                    dq_oe[0] ? dq_out[7:0] : pins.dq[7:0]};

  sdram_init_activate_access uut (
    .sys_clk_in        (sys_clk),
    .reset_in          (reset),
    .sdram_clk_in      (pins.clk),
    .cs_n_in           (pins.cs_n),
    .ras_n_in          (pins.ras_n),
    .cas_n_in          (pins.cas_n),
    .we_n_in           (pins.we_n),
    .cke_in            (pins.cke),
    .bank_select_0_in  (pins.bank_sel[0]),
    .bank_select_1_in  (pins.bank_sel[1]),
    .addr_in           (pins.addr),
    .byte_mask_lower_in(pins.mask[0]),
    .byte_mask_upper_in(pins.mask[1]),
    .data_bus_in       (dq_wire),
    .data_bus_out      (dq_out),
    .data_bus_oe_out   (dq_oe),
    .mode_reg_out      (mode_reg),
    .mode_valid_out    (mode_valid),
    .bank_open_out     (bank_open),
    .power_state_out   (power_state),
    .refresh_count_out (ref_count),
    .write_drop_out    (write_drop)
  );

  sdram_host_model host (
    .sys_clk_in   (sys_clk),
    .wire_dq_in   (dq_wire),
    .wire_oe_in   (dq_oe),
    .pins_out     (pins),
    .seen_data_out(seen_data),
    .seen_oe_out  (seen_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic op(input cmd_t c, input logic [1:0] b = 2'h0,
                    input logic [11:0] a = 12'h000,
                    input logic [1:0] m = 2'h0,
                    input logic [15:0] d = 16'h0000,
                    input logic cke = 1'b1, input logic cs_n = 1'b0);
    host.cmd_cycle(c, b, a, m, d, cke, cs_n);
  endtask : op

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Sticky: one command per link cycle can never fill the write queue
  always @(posedge sys_clk) begin
    if (!reset && write_drop !== 1'b0) drop_seen = 1'b1;
  end

  // Hang guard: the run needs about 20700 cycles
  initial cycles = 0;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("MISMATCH timeout expected finish seen hang");
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    errors       = 0;
    total_checks = 0;
    drop_seen    = 1'b0;
    reset        = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge sys_clk);
    check("mode_reg", 16'h0000, 16'(mode_reg));
    check("mode_valid", 16'h0000, 16'(mode_valid));
    check("bank_open", 16'h0000, 16'(bank_open));
    check("oe", 16'h0000, 16'(dq_oe));
    $display("test reset done");

    // Power-up pause of 200 us in no-ops, masks and clock gate high
    repeat (1250) op(CMD_NOP, 2'h0, 12'h000, 2'h3);
    op(CMD_PRE, 2'h0, 12'h400);
    for (int i = 0; i < 9; i++) op(CMD_REF);
    check("refresh_count", 16'h0008, 16'(ref_count));
    op(CMD_MRS, 2'h0, 12'h037);
    check("mode_reg", 16'h0037, 16'(mode_reg));
    check("mode_valid", 16'h0001, 16'(mode_valid));
    op(CMD_NOP);
    $display("test init done");

    // Open every bank, spaced by a no-op
    for (int b = 0; b < 4; b++) begin
      op(CMD_ACT, 2'(b), 12'(b + 1));
      op(CMD_NOP);
    end
    check("bank_open", 16'h000F, 16'(bank_open));
    op(CMD_PRE, 2'h2, 12'h000);
    check("bank_open", 16'h000B, 16'(bank_open));
    op(CMD_ACT, 2'h2, 12'h001, 2'h0, 16'h0000, 1'b1, 1'b1);
    check("bank_open", 16'h000B, 16'(bank_open));
    $display("test activate done");

    // Back-to-back writes and reads; column ignores A8 and A9
    op(CMD_WRITE, 2'h0, 12'h305, 2'h0, 16'h1234);
    op(CMD_WRITE, 2'h1, 12'h005, 2'h0, 16'h5555);
    op(CMD_WRITE, 2'h1, 12'h005, 2'h2, 16'hABCD);
    op(CMD_READ, 2'h0, 12'h005);
    op(CMD_READ, 2'h1, 12'h005);
    op(CMD_READ, 2'h0, 12'h005, 2'h1);
    check("read0", 16'h1234, seen_data);
    check("read0_oe", 16'h0003, 16'(seen_oe));
    op(CMD_READ, 2'h2, 12'h005);
    check("read1", 16'h55CD, seen_data);
    op(CMD_NOP);
    check("read2_hi", 16'h0012, 16'(seen_data[15:8]));
    check("read2_oe", 16'h0002, 16'(seen_oe));
    op(CMD_NOP);
    // Read of the closed bank never drives the bus
    check("closed_oe", 16'h0000, 16'(seen_oe));
    $display("test access done");

    // Clock gate: power-down, self-refresh, suspend, each left again
    op(CMD_PRE, 2'h0, 12'h400);
    check("bank_open", 16'h0000, 16'(bank_open));
    op(CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    check("power", 16'(PWR_DOWN), 16'(power_state));
    op(CMD_ACT, 2'h1, 12'h000, 2'h0, 16'h0000, 1'b0);
    check("bank_open", 16'h0000, 16'(bank_open));
    op(CMD_NOP);
    check("power", 16'(PWR_ACTIVE), 16'(power_state));
    op(CMD_REF, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    check("power", 16'(PWR_SELFREF), 16'(power_state));
    op(CMD_NOP);
    op(CMD_ACT, 2'h3, 12'h000);
    op(CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    check("power", 16'(PWR_SUSPEND), 16'(power_state));
    op(CMD_NOP);
    check("power", 16'(PWR_ACTIVE), 16'(power_state));
    op(CMD_PRE, 2'h0, 12'h400);
    check("write_drop", 16'h0000, 16'(drop_seen));
    $display("test clock gate done");
    tally_and_finish();
  end

endmodule : sdram_init_activate_access_tb_top
